// *** logic/host_seq_consts.svh ***
// Register offsets, field positions, reset values and fixed codes
// Assumes APB byte addresses, one 32-bit word per register
`ifndef HOST_SEQ_CONSTS_SVH
`define HOST_SEQ_CONSTS_SVH
// ==========================================
// Register offsets
`define OFS_SINGLE_OP_DMA_ADDR   8'h00
`define OFS_XFER_MODE   8'h04
`define OFS_COMMAND     8'h08
`define OFS_CLK_PWR     8'h0c
`define OFS_STATUS      8'h10
`define OFS_CAPS        8'h14
`define OFS_RESP_UPPER  8'h1c
`define OFS_DESC_LO     8'h58
`define OFS_DESC_HI     8'h5c
// ==========================================
// Field positions
`define XM_AUTO_STOP    0
`define XM_MULTI        1
`define XM_DATA         2
`define XM_DMA          3
`define XM_ADDR64       4
`define CP_POWER        0
`define CP_GATE         1
`define CP_DIV_LSB      8
`define ST_NOT_EXEC_STOP 4
`define ST_NOT_EXEC_CMD 5
`define ST_AUTO_ERR     6
`define ST_DMA_ERR      7
`define ST_W1C_MASK     32'h0000_00ff
`define DESC_VALID      0
`define DESC_END        1
`define DESC_ACT_LO     4
`define DESC_ACT_HI     5
// ==========================================
// Reset values and fixed codes
`define XM_RESET        5'h00
`define DIV_RESET       8'h00
`define STOP_CMD_INDEX  6'h0c
`define BASE_CLOCK_MHZ  8'hc8
`define LINE_BYTES      64'h0000_0000_0000_0008
`endif

// *** logic/host_seq_pkg.sv ***
// Types used by the card bus sequencer for its arbiter, DMA engine and card detect
// Assumes one-hot codes for arbiter and DMA states; card detect codes are binary
package host_seq_pkg;
  typedef enum logic [2:0] {
    ARB_IDLE = 3'b001,
    ARB_SW   = 3'b010,
    ARB_STOP = 3'b100
  } arb_state_t;
  typedef enum logic [3:0] {
    DMA_IDLE  = 4'b0001,
    DMA_FETCH = 4'b0010,
    DMA_EXEC  = 4'b0100,
    DMA_HALT  = 4'b1000
  } dma_state_t;
  typedef enum logic [1:0] {
    CARD_NONE     = 2'b00,
    CARD_DEBOUNCE = 2'b01,
    CARD_INSERTED = 2'b10
  } card_det_t;
endpackage

// *** logic/card_clock_gen.sv ***
// Card bus clock generator with gated, duty-preserving start and stop
// Assumes ref_clk is the advertised base clock
`timescale 1ns/1ps
module card_clock_gen (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       power_on,
  input  wire logic       gate,
  input  wire logic [7:0] divider,
  output logic            card_bus_clock,
  output logic            running
);
  logic [7:0] half;
  logic [7:0] cnt;

  // Half period in base clocks; zero divider means divide by two
  // divider on base clock
  assign half = (divider == 8'h00) ? 8'h01 : divider;

  // Clock phase sequencer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      card_bus_clock <= 1'b0;
      running        <= 1'b0;
      cnt            <= 8'h00;
    end
    else if (!power_on)
    begin
      card_bus_clock <= 1'b0;
      running        <= 1'b0;
      cnt            <= 8'h00;
    end
    else if (!running)
    begin
      if (gate)
      begin
        card_bus_clock <= 1'b1;
        running        <= 1'b1;
        cnt            <= half - 8'h01;
      end
    end
    else if (!gate && !card_bus_clock)
      running <= 1'b0;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
    else
    begin
      card_bus_clock <= ~card_bus_clock & gate;
      running        <= gate;
      cnt            <= half - 8'h01;
    end
  end

  AST_POWER_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !power_on |=> !card_bus_clock)
    else $error("card clock not low after power off");
  AST_HIGH_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (power_on && running && card_bus_clock && cnt != 8'h00) |=> card_bus_clock)
    else $error("high phase cut short");
  AST_START_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (power_on && $rose(card_bus_clock)) |-> cnt == half - 8'h01)
    else $error("clock started without full high");
endmodule

// *** logic/card_bus_sequencer.sv ***
// Card host bus sequencer: APB registers, auto stop, clocking, descriptor DMA
// Assumes card command engine and memory port on ref_clk; card detect from pins
//
// Functional notes
// - Auto stop sent by hardware after last block when enabled.
// - Stop timing follows the last block done event, not software.
// - Command line arbitrated; software command may go before or after stop.
// - Stop response kept in upper response word at 1Ch.
// - Stop errors raise auto error flag with index, end, CRC, timeout.
// - Failed dataless command before stop cancels stop, flagged not executed.
// - Failed stop cancels pending dataless command, flagged not executed.
// - Card clock period from divider on advertised base clock.
// - Card clock duty is fifty percent.
// - Clock start begins with a full high phase.
// - Gate clear finishes high phase then holds low.
// - Power off drives clock low at once and clears gate.
// - Clock low while power off; runs only with gate set.
// - Debounce to no card clears card power.
// - Inserted to debounce clears clock gate at once.
// - DMA uses descriptor pointer at 58h, ignores single-op address.
// - Command write launches DMA; lines run until end attribute.
// - 32-bit addressing uses low half of pointers only.
// - Invalid line flags DMA error and halts.
// - Action bits: skip, skip, transfer, link.
`timescale 1ns/1ps
`include "host_seq_consts.svh"
module card_bus_sequencer (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  card_detect,
  output logic             cmd_start,
  output logic [5:0]       cmd_index,
  output logic             cmd_has_data,
  input  wire logic        cmd_done,
  input  wire logic [3:0]  cmd_err,
  input  wire logic [31:0] cmd_resp,
  input  wire logic        last_block_done,
  output logic             card_bus_clock,
  output logic             desc_fetch_req,
  output logic [63:0]      desc_fetch_addr,
  input  wire logic        desc_fetch_ack,
  input  wire logic [63:0] desc_line,
  output logic             xfer_start,
  output logic [63:0]      xfer_addr,
  output logic [15:0]      xfer_len,
  input  wire logic        xfer_done
);
  import host_seq_pkg::*;

  logic [31:0] single_dma_system_address;
  logic [31:0] command_response_upper;
  logic [63:0] descriptor_pointer;
  logic [4:0]  xfer_mode;
  logic        card_power_on;
  logic        card_clock_gate;
  logic [7:0]  card_clock_divider;
  logic [7:0]  status_flags;
  logic [7:0]  next_status_flags;
  logic        clock_running;
  logic [1:0]  det_s1;
  logic [1:0]  det_s2;
  logic [1:0]  det_s3;
  logic [1:0]  det_q;
  arb_state_t  arb;
  dma_state_t  dma;
  logic        sw_pend;
  logic [5:0]  sw_idx;
  logic        sw_data;
  logic        armed;
  logic        stop_pend;
  logic        line_end;
  logic        wr_access;
  logic        wr_command;
  logic        stop_fail;
  logic        sw_fail;
  logic        dma_launch;
  logic [31:0] read_word;

  // Address match helper
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Keep only the low half unless 64-bit addressing
  // low half in 32-bit mode
  function automatic logic [63:0] addr_mask(input logic [63:0] a, input logic wide);
    addr_mask = wide ? a : {32'h0000_0000, a[31:0]};
  endfunction

  // ==========================================
  // APB slave
  // Zero wait states; unmapped offsets answer with pslverr
  assign pready     = 1'b1;
  assign wr_access  = psel && penable && pwrite;
  assign wr_command = wr_access && reg_hit(paddr, `OFS_COMMAND);

  always_comb
  begin
    read_word = 32'h0000_0000;
    unique case (paddr)
      `OFS_SINGLE_OP_DMA_ADDR:  read_word = single_dma_system_address;
      `OFS_XFER_MODE:  read_word = {27'h0, xfer_mode};
      `OFS_COMMAND:    read_word = {26'h0, sw_idx};
      `OFS_CLK_PWR:    read_word = {16'h0, card_clock_divider, 6'h00,
                                    card_clock_gate, card_power_on};
      `OFS_STATUS:     read_word = {18'h0, det_q, 1'b0, sw_pend | ~arb[0],
                                    clock_running, ~dma[0], status_flags};
      `OFS_CAPS:       read_word = {24'h0, `BASE_CLOCK_MHZ};
      `OFS_RESP_UPPER: read_word = command_response_upper;
      `OFS_DESC_LO:    read_word = descriptor_pointer[31:0];
      `OFS_DESC_HI:    read_word = descriptor_pointer[63:32];
      default:         read_word = 32'h0000_0000;
    endcase
  end

  assign pslverr = psel && penable && !(reg_hit(paddr, `OFS_SINGLE_OP_DMA_ADDR)
                   || reg_hit(paddr, `OFS_XFER_MODE) || reg_hit(paddr, `OFS_COMMAND)
                   || reg_hit(paddr, `OFS_CLK_PWR) || reg_hit(paddr, `OFS_STATUS)
                   || reg_hit(paddr, `OFS_CAPS) || reg_hit(paddr, `OFS_RESP_UPPER)
                   || reg_hit(paddr, `OFS_DESC_LO) || reg_hit(paddr, `OFS_DESC_HI));

  // Read data latched in the setup cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= read_word;
  end

  // Plain software registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      single_dma_system_address <= 32'h0000_0000;
      descriptor_pointer        <= 64'h0;
      xfer_mode                 <= `XM_RESET;
    end
    else if (wr_access)
    begin
      if (reg_hit(paddr, `OFS_SINGLE_OP_DMA_ADDR))
        single_dma_system_address <= pwdata;
      if (reg_hit(paddr, `OFS_XFER_MODE))
        xfer_mode <= pwdata[4:0];
      if (reg_hit(paddr, `OFS_DESC_LO))
        descriptor_pointer[31:0] <= pwdata;
      if (reg_hit(paddr, `OFS_DESC_HI))
        descriptor_pointer[63:32] <= pwdata;
    end
  end

  // ==========================================
  // Card detect and power / clock control
  // Two-stage synchroniser; a state is accepted once two samples agree
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      det_s1 <= CARD_NONE;
      det_s2 <= CARD_NONE;
      det_s3 <= CARD_NONE;
      det_q  <= CARD_NONE;
    end
    else
    begin
      det_s1 <= card_detect;
      det_s2 <= det_s1;
      det_s3 <= det_s2;
      if (det_s2 == det_s3)
        det_q <= det_s2;
    end
  end

  // Software writes first, hardware clears override
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      card_power_on      <= 1'b0;
      card_clock_gate    <= 1'b0;
      card_clock_divider <= `DIV_RESET;
    end
    else
    begin
      if (wr_access && reg_hit(paddr, `OFS_CLK_PWR))
      begin
        card_power_on      <= pwdata[`CP_POWER];
        card_clock_gate    <= pwdata[`CP_GATE] & pwdata[`CP_POWER];
        card_clock_divider <= pwdata[`CP_DIV_LSB +: 8];
      end
      if (det_q == CARD_DEBOUNCE && det_s2 == CARD_NONE && det_s3 == CARD_NONE)
      begin
        card_power_on   <= 1'b0;
        card_clock_gate <= 1'b0;
      end
      if (det_q == CARD_INSERTED && det_s2 == CARD_DEBOUNCE && det_s3 == CARD_DEBOUNCE)
        card_clock_gate <= 1'b0;
    end
  end

  card_clock_gen u_clk (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .power_on       (card_power_on),
    .gate           (card_clock_gate),
    .divider        (card_clock_divider),
    .card_bus_clock (card_bus_clock),
    .running        (clock_running)
  );

  // ==========================================
  // Command arbiter and auto stop
  assign stop_fail = (arb == ARB_STOP) && cmd_done && (cmd_err != 4'h0);
  assign sw_fail   = (arb == ARB_SW) && cmd_done && (cmd_err != 4'h0) && !sw_data;

  // One command on the line at a time; stop wins a tie
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arb          <= ARB_IDLE;
      sw_pend      <= 1'b0;
      sw_idx       <= 6'h00;
      sw_data      <= 1'b0;
      armed        <= 1'b0;
      stop_pend    <= 1'b0;
      cmd_start    <= 1'b0;
      cmd_index    <= 6'h00;
      cmd_has_data <= 1'b0;
    end
    else
    begin
      cmd_start <= 1'b0;
      if (wr_command)
      begin
        sw_pend <= 1'b1;
        sw_idx  <= pwdata[5:0];
        sw_data <= xfer_mode[`XM_DATA];
        if (xfer_mode[`XM_DATA] && xfer_mode[`XM_MULTI] && xfer_mode[`XM_AUTO_STOP])
          armed <= 1'b1;
      end
      if (last_block_done && armed)
      begin
        stop_pend <= 1'b1;
        armed     <= 1'b0;
      end
      unique case (arb)
        ARB_IDLE:
          if (stop_pend)
          begin
            arb          <= ARB_STOP;
            cmd_start    <= 1'b1;
            cmd_index    <= `STOP_CMD_INDEX;
            cmd_has_data <= 1'b0;
            stop_pend    <= 1'b0;
          end
          else if (sw_pend && !wr_command)
          begin
            arb          <= ARB_SW;
            cmd_start    <= 1'b1;
            cmd_index    <= sw_idx;
            cmd_has_data <= sw_data;
            sw_pend      <= 1'b0;
          end
        ARB_SW:
          if (cmd_done)
          begin
            arb <= ARB_IDLE;
            if (sw_fail)
            begin
              stop_pend <= 1'b0;
              armed     <= 1'b0;
            end
          end
        ARB_STOP:
          if (cmd_done)
          begin
            arb <= ARB_IDLE;
            if (stop_fail && sw_pend && !sw_data && !wr_command)
              sw_pend <= 1'b0;
          end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      command_response_upper <= 32'h0000_0000;
    else if (arb == ARB_STOP && cmd_done)
      command_response_upper <= cmd_resp;
  end

  // Sticky error flags; a new event wins over a write-one clear
  always_comb
  begin
    next_status_flags = status_flags;
    if (wr_access && reg_hit(paddr, `OFS_STATUS))
      next_status_flags = status_flags & ~pwdata[7:0];
    if (stop_fail)
    begin
      next_status_flags[3:0]          = next_status_flags[3:0] | cmd_err;
      next_status_flags[`ST_AUTO_ERR] = 1'b1;
    end
    if (sw_fail && (stop_pend || (last_block_done && armed)))
    begin
      next_status_flags[`ST_NOT_EXEC_STOP] = 1'b1;
      next_status_flags[`ST_AUTO_ERR]      = 1'b1;
    end
    if (stop_fail && sw_pend && !sw_data && !wr_command)
      next_status_flags[`ST_NOT_EXEC_CMD] = 1'b1;
    if (dma == DMA_FETCH && desc_fetch_ack && !desc_line[`DESC_VALID])
      next_status_flags[`ST_DMA_ERR] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_flags <= 8'h00;
    else
      status_flags <= next_status_flags;
  end

  // ==========================================
  // Scatter-gather descriptor engine
  assign dma_launch     = wr_command && xfer_mode[`XM_DMA] && xfer_mode[`XM_DATA];
  assign desc_fetch_req = (dma == DMA_FETCH);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dma             <= DMA_IDLE;
      desc_fetch_addr <= 64'h0;
      xfer_start      <= 1'b0;
      xfer_addr       <= 64'h0;
      xfer_len        <= 16'h0000;
      line_end        <= 1'b0;
    end
    else
    begin
      xfer_start <= 1'b0;
      unique case (dma)
        DMA_IDLE, DMA_HALT:
          if (dma_launch)
          begin
            dma             <= DMA_FETCH;
            desc_fetch_addr <= addr_mask(descriptor_pointer, xfer_mode[`XM_ADDR64]);
          end
        DMA_FETCH:
          if (desc_fetch_ack)
          begin
            line_end <= desc_line[`DESC_END];
            if (!desc_line[`DESC_VALID])
              dma <= DMA_HALT;
            else if (desc_line[`DESC_ACT_HI] && !desc_line[`DESC_ACT_LO])
            begin
              dma        <= DMA_EXEC;
              xfer_start <= 1'b1;
              xfer_addr  <= {32'h0000_0000, desc_line[63:32]};
              xfer_len   <= desc_line[31:16];
            end
            else if (desc_line[`DESC_ACT_HI])
            begin
              dma             <= desc_line[`DESC_END] ? DMA_IDLE : DMA_FETCH;
              desc_fetch_addr <= {32'h0000_0000, desc_line[63:32]};
            end
            else
            begin
              dma             <= desc_line[`DESC_END] ? DMA_IDLE : DMA_FETCH;
              desc_fetch_addr <= addr_mask(desc_fetch_addr + `LINE_BYTES,
                                           xfer_mode[`XM_ADDR64]);
            end
          end
        DMA_EXEC:
          if (xfer_done)
          begin
            dma             <= line_end ? DMA_IDLE : DMA_FETCH;
            desc_fetch_addr <= addr_mask(desc_fetch_addr + `LINE_BYTES,
                                         xfer_mode[`XM_ADDR64]);
          end
      endcase
    end
  end

  // ==========================================
  // Checks
  // stop issued when free
  AST_STOP_ISSUE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arb == ARB_IDLE && stop_pend) |=> (cmd_start && cmd_index == `STOP_CMD_INDEX))
    else $error("auto stop not issued");
  AST_NO_STRAY_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!armed && !stop_pend) |=> !stop_pend)
    else $error("stop pending without arming");
  AST_RESP_UPPER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arb == ARB_STOP && cmd_done) |=> command_response_upper == $past(cmd_resp))
    else $error("stop response not stored");
  AST_STOP_CANCEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sw_fail && stop_pend) |=> (!stop_pend && status_flags[`ST_NOT_EXEC_STOP]))
    else $error("stop not cancelled after dataless failure");
  AST_CMD_CANCEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (stop_fail && sw_pend && !sw_data && !wr_command)
    |=> (!sw_pend && status_flags[`ST_NOT_EXEC_CMD]))
    else $error("dataless command not cancelled");
  AST_AUTO_ERR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stop_fail |=> (status_flags[`ST_AUTO_ERR] && (status_flags[3:0] & $past(cmd_err))
                   == $past(cmd_err)))
    else $error("auto stop error not recorded");
  AST_ADDR_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (desc_fetch_req && !xfer_mode[`XM_ADDR64]) |-> desc_fetch_addr[63:32] == 32'h0)
    else $error("upper address used in 32-bit mode");
  AST_DMA_HALT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (desc_fetch_req && desc_fetch_ack && !desc_line[`DESC_VALID])
    |=> (dma == DMA_HALT && status_flags[`ST_DMA_ERR]) ##1 !desc_fetch_req)
    else $error("engine ran on after invalid line");
  AST_POWER_DROP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (det_q == CARD_DEBOUNCE && det_s2 == CARD_NONE && det_s3 == CARD_NONE)
    |=> !card_power_on ##1 !card_bus_clock)
    else $error("power kept after card removal");
endmodule

// *** tb/card_partner.sv ***
// Behavioural card and memory side of the card bus sequencer
// Assumes every handshake is sampled on rising ref_clk edges
`timescale 1ns/1ps
module card_partner (
  input  wire logic             ref_clk,
  input  wire logic             cmd_start,
  input  wire logic [3:0]       err_set,
  input  wire logic [31:0]      resp_set,
  output logic                  cmd_done,
  output logic [3:0]            cmd_err,
  output logic [31:0]           cmd_resp,
  input  wire logic             desc_fetch_req,
  input  wire logic [63:0]      desc_fetch_addr,
  input  wire logic [7:0][63:0] table_set,
  output logic                  desc_fetch_ack,
  output logic [63:0]           desc_line,
  input  wire logic             xfer_start,
  output logic                  xfer_done
);
  int cc = 0;
  int fc = 0;
  int xc = 0;
  initial {cmd_done, cmd_err, cmd_resp, desc_fetch_ack, desc_line, xfer_done} = '0;
  // ==========================================
  // Replies: response data is only meaningful beside its strobe
  always @(posedge ref_clk)
  begin
    cmd_done <= 1'h0;
    cmd_err <= ~cmd_err;
    cmd_resp <= ~cmd_resp;
    desc_fetch_ack <= 1'h0;
    desc_line <= ~desc_line;
    xfer_done <= 1'h0;
    if (cmd_start === 1'h1) cc <= 4;
    else if (cc > 1) cc <= cc - 1;
    else if (cc == 1)
    begin
      cc <= 0;
      cmd_done <= 1'h1;
      cmd_err <= err_set;
      cmd_resp <= resp_set;
    end
    if (fc == 2)
    begin
      fc <= 0;
      desc_fetch_ack <= 1'h1;
      desc_line <= table_set[desc_fetch_addr[5:3]];
    end
    else if (desc_fetch_req === 1'h1 && !desc_fetch_ack) fc <= fc + 1;
    if (xfer_start === 1'h1) xc <= 3;
    else if (xc > 1) xc <= xc - 1;
    else if (xc == 1)
    begin
      xc <= 0;
      xfer_done <= 1'h1;
    end
  end
endmodule

// *** tb/test_card_bus_sequencer.sv ***
// Self-checking bench for the card bus sequencer over APB
// Assumes card_partner answers commands, descriptor fetches and transfers
`timescale 1ns/1ps
`include "host_seq_consts.svh"
module test_card_bus_sequencer;
  logic             ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]       paddr = 0;
  logic [31:0]      pwdata = 0, prdata, rd, resp_set = 0, cmd_resp;
  logic             pready, pslverr, err_seen, cmd_start, cmd_has_data, cmd_done;
  logic             last_block_done = 0, card_bus_clock, desc_fetch_req, desc_fetch_ack;
  logic             xfer_start, xfer_done;
  logic [1:0]       card_detect = 2'h2;
  logic [5:0]       cmd_index;
  logic [3:0]       cmd_err, err_set = 0;
  logic [63:0]      desc_fetch_addr, desc_line, xfer_addr;
  logic [15:0]      xfer_len;
  logic [7:0][63:0] table_set = '0;
  logic [63:0]      cq[$], fq[$], xq[$], hq[$];
  logic [7:0]       dv;
  int               fails = 0, num_checks = 0, hc = 0;
  card_bus_sequencer u_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .card_detect, .cmd_start, .cmd_index, .cmd_has_data,
    .cmd_done, .cmd_err, .cmd_resp, .last_block_done, .card_bus_clock, .desc_fetch_req,
    .desc_fetch_addr, .desc_fetch_ack, .desc_line, .xfer_start, .xfer_addr, .xfer_len,
    .xfer_done);
  card_partner u_partner (.ref_clk, .cmd_start, .err_set, .resp_set, .cmd_done, .cmd_err,
    .cmd_resp, .desc_fetch_req, .desc_fetch_addr, .table_set, .desc_fetch_ack, .desc_line,
    .xfer_start, .xfer_done);
  initial forever #2.5 ref_clk = ~ref_clk;
  // Watchdog cuts a hang short
  initial
  begin
    #50000;
    fails++;
    wrap_up();
  end
  // ==========================================
  // Observed results: commands, fetches, transfers, card clock high runs
  always @(negedge ref_clk)
  begin
    if (cmd_start === 1'h1) cq.push_back(64'({cmd_has_data, cmd_index}));
    if (desc_fetch_ack === 1'h1) fq.push_back(desc_fetch_addr);
    if (xfer_start === 1'h1) xq.push_back({xfer_addr[31:0], 16'h0, xfer_len});
    if (card_bus_clock === 1'h1) hc++;
    else if (hc != 0)
    begin
      hq.push_back(64'(hc));
      hc = 0;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic qchk(ref logic [63:0] q[$], input logic [63:0] e[$]);
    chk(64'(q.size()), 64'(e.size()));
    foreach (e[i]) chk(q[i], e[i]);
    q.delete();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(64'(rd & m), 64'(e));
  endtask
  task automatic wdone();
    repeat (40)
    begin
      @(posedge ref_clk);
      if (cmd_done === 1'h1) break;
    end
  endtask
  task automatic blk_end();
    @(posedge ref_clk);
    last_block_done <= 1'h1;
    @(posedge ref_clk);
    last_block_done <= 1'h0;
  endtask
  task automatic data_cmd(input logic [4:0] mode);
    apb(1'h1, `OFS_XFER_MODE, {27'h0, mode});
    apb(1'h1, `OFS_COMMAND, 32'h12);
    wdone();
  endtask
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    dv = 8'($urandom(36));
    dv = 8'($urandom_range(3, 1));
    resp_set = $urandom();
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    rdchk(`OFS_CAPS, 32'hff, `BASE_CLOCK_MHZ);
    apb(1'h0, 8'h40, 32'h0);
    chk(64'(err_seen), 64'h1);
    data_cmd(5'h07);
    repeat (5) @(posedge ref_clk);
    qchk(cq, '{64'h52});
    blk_end();
    wdone();
    qchk(cq, '{64'h0c});
    rdchk(`OFS_RESP_UPPER, 32'hffffffff, resp_set);
    data_cmd(5'h05);
    blk_end();
    data_cmd(5'h06);
    blk_end();
    repeat (12) @(posedge ref_clk);
    qchk(cq, '{64'h52, 64'h52});
    data_cmd(5'h07);
    apb(1'h1, `OFS_XFER_MODE, 32'h0);
    err_set = 4'h4;
    blk_end();
    apb(1'h1, `OFS_COMMAND, 32'h0d);
    repeat (20) @(posedge ref_clk);
    qchk(cq, '{64'h52, 64'h0c});
    rdchk(`OFS_STATUS, 32'hff, 32'h64);
    apb(1'h1, `OFS_STATUS, 32'hff);
    data_cmd(5'h07);
    apb(1'h1, `OFS_XFER_MODE, 32'h0);
    err_set = 4'h1;
    apb(1'h1, `OFS_COMMAND, 32'h0d);
    blk_end();
    repeat (20) @(posedge ref_clk);
    err_set = 4'h0;
    qchk(cq, '{64'h52, 64'h0d});
    rdchk(`OFS_STATUS, 32'hf0, 32'h50);
    apb(1'h1, `OFS_COMMAND, 32'h0c);
    wdone();
    qchk(cq, '{64'h0c});
    apb(1'h1, `OFS_STATUS, 32'hff);
    rdchk(`OFS_STATUS, 32'hff, 32'h0);
    apb(1'h1, `OFS_CLK_PWR, {16'h0, dv, 8'h3});
    repeat (40) @(posedge ref_clk);
    apb(1'h1, `OFS_CLK_PWR, {16'h0, dv, 8'h1});
    repeat (20) @(posedge ref_clk);
    chk(64'(card_bus_clock), 64'h0);
    chk(64'(hq.size() > 2), 64'h1);
    foreach (hq[i]) chk(hq[i], 64'(dv));
    apb(1'h1, `OFS_CLK_PWR, 32'h1003);
    repeat (60)
    begin
      @(posedge ref_clk);
      if (card_bus_clock === 1'h1) break;
    end
    apb(1'h1, `OFS_CLK_PWR, 32'h1002);
    repeat (2) @(posedge ref_clk);
    chk(64'(card_bus_clock), 64'h0);
    rdchk(`OFS_CLK_PWR, 32'h3, 32'h0);
    hq.delete();
    apb(1'h1, `OFS_CLK_PWR, 32'h1001);
    repeat (40) @(posedge ref_clk);
    chk(64'(hq.size()), 64'h0);
    apb(1'h1, `OFS_CLK_PWR, 32'h1003);
    repeat (60) @(posedge ref_clk);
    chk(hq[0], 64'h10);
    card_detect <= 2'h1;
    repeat (6) @(posedge ref_clk);
    rdchk(`OFS_CLK_PWR, 32'h3, 32'h1);
    card_detect <= 2'h0;
    repeat (6) @(posedge ref_clk);
    rdchk(`OFS_CLK_PWR, 32'h3, 32'h0);
    card_detect <= 2'h2;
    table_set[0] = 64'h0000_1000_0040_0021;
    table_set[1] = 64'h0000_0000_0000_0011;
    table_set[2] = 64'h0000_0000_0000_0001;
    table_set[3] = 64'h0000_0130_0000_0031;
    table_set[6] = 64'h0000_2000_0010_0023;
    apb(1'h1, `OFS_SINGLE_OP_DMA_ADDR, 32'h200);
    apb(1'h1, `OFS_DESC_LO, 32'h100);
    apb(1'h1, `OFS_DESC_HI, 32'h1);
    data_cmd(5'h0c);
    repeat (120) @(posedge ref_clk);
    qchk(fq, '{64'h100, 64'h108, 64'h110, 64'h118, 64'h130});
    qchk(xq, '{64'h0000_1000_0000_0040, 64'h0000_2000_0000_0010});
    rdchk(`OFS_STATUS, 32'h80, 32'h0);
    table_set[0] = 64'h0;
    apb(1'h1, `OFS_COMMAND, 32'h12);
    repeat (40) @(posedge ref_clk);
    qchk(fq, '{64'h100});
    rdchk(`OFS_STATUS, 32'h80, 32'h80);
    wrap_up();
  end
endmodule
